// [rtl/cbd_pkg.sv]
// Package of constants and types for the command block decoder.
// Assumes one system clock; shared by the decoder and its length counter.
package cbd_pkg;

  // ------------------------------------------------------------------
  // Operation code layout
  // ------------------------------------------------------------------
  localparam int OPC_GRP_MSB = 7;
  localparam int OPC_GRP_LSB = 5;
  localparam int OPC_CMD_MSB = 4;
  localparam logic [2:0] GRP_SHORT  = 3'h0;
  localparam logic [2:0] GRP_LONG   = 3'h1;
  localparam logic [2:0] GRP_VEND_A = 3'h6;
  localparam logic [2:0] GRP_VEND_B = 3'h7;

  // ------------------------------------------------------------------
  // Byte positions inside a command block
  // ------------------------------------------------------------------
  localparam int BYTE_OPC       = 0;
  localparam int BYTE_UNIT      = 1;
  localparam int BYTE_SHORT_LEN = 4;
  localparam int BYTE_SHORT_CTL = 5;
  localparam int BYTE_LONG_RSVD = 6;
  localparam int BYTE_LONG_LEN  = 7;
  localparam int BYTE_LONG_CTL  = 9;
  localparam int CB_BYTES       = 10;
  localparam logic [3:0] CB_LAST_SHORT = 4'h5;
  localparam logic [3:0] CB_LAST_LONG  = 4'h9;
  localparam logic [3:0] CB_NEXT_IDX   = 4'h1;
  localparam int UNIT_MSB      = 7;
  localparam int UNIT_LSB      = 5;
  localparam int SHORT_LBA_MSB = 4;

  // ------------------------------------------------------------------
  // Control byte: link, flag and vendor bits must be clear
  // ------------------------------------------------------------------
  localparam logic [7:0] CTL_CHECK_MASK = 8'hc3;

  // ------------------------------------------------------------------
  // Length limits
  // ------------------------------------------------------------------
  localparam logic [16:0] SHORT_ZERO_COUNT = 17'h00100;
  localparam logic [32:0] MAX_XFER_BYTES   = 33'h000010000;
  localparam logic [32:0] RECOMMEND_BYTES  = 33'h000004000;

  // How the length field is read, given by the opcode table outside
  typedef enum logic [1:0] {
    LEN_NONE   = 2'h0,
    LEN_BLOCKS = 2'h1,
    LEN_PARAM  = 2'h2,
    LEN_ALLOC  = 2'h3
  } cbd_len_kind_type;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0001,
    S_COLLECT = 4'b0010,
    S_CHECK   = 4'b0100,
    S_XFER    = 4'b1000
  } cbd_state_type;

  // Decoded command block
  typedef struct packed {
    logic [2:0]  group;
    logic [4:0]  command;
    logic [2:0]  unit_number;
    logic [31:0] lba;
    logic [15:0] length;
    logic [7:0]  control;
    logic        ten_byte;
  } cbd_cmd_type;

endpackage

// [rtl/cbd_xfer.sv]
// Byte counter that bounds one data phase of a command.
// Assumes start and beat come from logic on the same clock.
`timescale 1ns/1ps
module cbd_xfer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [16:0] limit,
  input  wire logic        beat,
  output logic             active,
  output logic [16:0]      remaining,
  output logic             done
);
  import cbd_pkg::*;

  logic last_beat;

  // ------------------------------------------------------------------
  // Count down the bytes still allowed in this phase
  // ------------------------------------------------------------------
  assign last_beat = active & beat & (remaining == 17'h00001);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active    <= 1'b0;
      remaining <= 17'h00000;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        remaining <= limit;
        active    <= (limit != 17'h00000);
        done      <= (limit == 17'h00000); // Empty phase ends at once
      end else if (active & beat) begin
        remaining <= remaining - 17'h00001;
        active    <= ~last_beat;
        done      <= last_beat;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_zero_phase;
    @(posedge clk) disable iff (reset)
    start && limit == 17'h00000 |=> done && !active;
  endproperty
  a_zero_phase: assert property (p_zero_phase)
    else $error("empty phase did not end at once");

  property p_phase_stop;
    @(posedge clk) disable iff (reset)
    active && beat && remaining == 17'h00001 && !start |=> !active && done;
  endproperty
  a_phase_stop: assert property (p_phase_stop)
    else $error("phase ran past its byte limit");

endmodule

// [rtl/cbd_decoder.sv]
// Command block decoder: gathers a command block byte by byte, splits
// out its fields, checks them and bounds the following data phase.
// Assumes bytes, identify unit and opcode table answers arrive from
// logic on the same clock, and that the bus side moves one byte per beat.
//
// Notes on behaviour
// - Opcode is three-bit group plus five-bit command
// - Group zero six bytes, group one ten
// - Groups two to five refused, six seven vendor
// - Short block: unit, 21-bit address, length, control
// - Long block: unit, 32-bit address, 16-bit length
// - Without identify, unit from byte one top bits
// - Invalid parameter ends command, medium untouched
// - Addresses run gapless from zero to last
// - Transfer length counts blocks unless bytes defined
// - One-byte length zero means 256 blocks
// - Multi-byte length zero moves no data
// - Same encodings for parameter and allocation lengths
// - Never more than 64 kilobytes per command
// - Sixteen kilobytes per command is recommended
// - Parameter list length is data-out byte count
// - Zero allocation returns nothing, no error; a six-byte block here reads zero as 256
// - Data-in stops at smaller of allocation, available
`timescale 1ns/1ps
module cbd_decoder (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      cmd_byte_valid,
  input  wire logic [7:0]                cmd_byte,
  output logic                           cmd_byte_ready,
  input  wire logic                      identify_valid,
  input  wire logic [2:0]                identify_unit,
  input  wire cbd_pkg::cbd_len_kind_type len_kind,
  input  wire logic                      dir_in,
  input  wire logic [16:0]               data_avail,
  input  wire logic [31:0]               unit_blocks,
  input  wire logic [3:0]                blk_log2,
  input  wire logic                      data_beat,
  output cbd_pkg::cbd_cmd_type           cmd_info,
  output logic [16:0]                    cmd_count,
  output logic [16:0]                    xfer_bytes,
  output logic                           cmd_valid,
  output logic                           cmd_reject,
  output logic                           vendor_cmd,
  output logic                           over_recommend,
  output logic                           xfer_active,
  output logic                           xfer_dir_in,
  output logic [16:0]                    xfer_remaining,
  output logic                           xfer_done,
  output logic                           medium_write_en,
  output logic                           cmd_done
);
  import cbd_pkg::*;

  cbd_state_type    state;
  cbd_state_type    next_state;
  cbd_len_kind_type cur_kind;
  logic [7:0]       cb [0:CB_BYTES-1];
  logic [3:0]       idx;
  logic             ten;

  // ------------------------------------------------------------------
  // Operation code split of the incoming first byte
  // ------------------------------------------------------------------
  logic [2:0] in_group;
  logic       in_known;
  logic       in_vendor;
  assign in_group  = cmd_byte[OPC_GRP_MSB:OPC_GRP_LSB];
  assign in_known  = (in_group == GRP_SHORT) | (in_group == GRP_LONG);
  assign in_vendor = (in_group == GRP_VEND_A) | (in_group == GRP_VEND_B);

  // ------------------------------------------------------------------
  // Field extraction from the collected bytes
  // ------------------------------------------------------------------
  logic [31:0] lba_short;
  logic [31:0] lba_long;
  logic [31:0] f_lba;
  logic [15:0] f_len;
  logic [7:0]  f_ctl;
  logic [2:0]  f_unit;
  logic [16:0] f_count;
  logic [32:0] blk_bytes;
  logic [32:0] lba_end;
  // Short block: top address bits share byte one with the unit
  assign lba_short = {11'h000, cb[BYTE_UNIT][SHORT_LBA_MSB:0],
                      cb[2], cb[3]};
  // Long block: four address bytes, first one highest
  assign lba_long  = {cb[2], cb[3], cb[4], cb[5]};
  assign f_lba     = ten ? lba_long : lba_short;
  assign f_len     = ten ? {cb[BYTE_LONG_LEN], cb[BYTE_LONG_LEN+1]}
                         : {8'h00, cb[BYTE_SHORT_LEN]};
  assign f_ctl     = ten ? cb[BYTE_LONG_CTL] : cb[BYTE_SHORT_CTL];
  // Identify message wins over the field in the block
  assign f_unit    = identify_valid ? identify_unit
                   : cb[BYTE_UNIT][UNIT_MSB:UNIT_LSB];

  // Length encodings, alike for all three length kinds
  assign f_count = ten ? {1'b0, f_len}
                 : (f_len == 16'h0000) ? SHORT_ZERO_COUNT
                 : {1'b0, f_len};
  assign blk_bytes = 33'(f_count) << blk_log2;
  assign lba_end   = {1'b0, f_lba} + 33'(f_count);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  logic rsvd_bad;
  logic ctl_bad;
  logic unit_bad;
  logic range_bad;
  logic size_bad;
  logic param_bad;
  assign rsvd_bad  = ten & ((cb[BYTE_LONG_RSVD] != 8'h00)
                   | (cb[BYTE_UNIT][SHORT_LBA_MSB:0] != 5'h00));
  assign ctl_bad   = (f_ctl & CTL_CHECK_MASK) != 8'h00;
  // Named unit must not also sit in the block
  assign unit_bad  = identify_valid
                   & (cb[BYTE_UNIT][UNIT_MSB:UNIT_LSB] != 3'h0);
  // Blocks run from zero up to the last block of the unit
  assign range_bad = (len_kind == LEN_BLOCKS) & (f_count != 17'h00000)
                   & (lba_end > {1'b0, unit_blocks});
  assign size_bad  = (len_kind == LEN_BLOCKS)
                   & (blk_bytes > MAX_XFER_BYTES);
  assign param_bad = rsvd_bad | ctl_bad | unit_bad | range_bad | size_bad;

  // ------------------------------------------------------------------
  // Byte limit of the data phase
  // ------------------------------------------------------------------
  logic [16:0] phase_limit;
  logic        alloc_short;
  logic        xfer_start;
  assign alloc_short = f_count < data_avail;
  assign phase_limit =
      (len_kind == LEN_BLOCKS) ? blk_bytes[16:0]
    : (len_kind == LEN_PARAM)  ? f_count
    : (len_kind == LEN_ALLOC)  ? (alloc_short ? f_count
                                              : data_avail)
    : 17'h00000;
  assign xfer_start = (state == S_CHECK) & ~param_bad;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  logic byte_take;
  logic last_byte;
  assign cmd_byte_ready = (state == S_IDLE) | (state == S_COLLECT);
  assign byte_take      = cmd_byte_valid & cmd_byte_ready;
  assign last_byte      = idx == (ten ? CB_LAST_LONG
                                      : CB_LAST_SHORT);

  // Next state from the byte stream and the phase counter
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (byte_take & in_known) begin
          next_state = S_COLLECT;
        end
      end
      S_COLLECT: begin
        if (byte_take & last_byte) begin
          next_state = S_CHECK;
        end
      end
      S_CHECK: begin
        next_state = param_bad ? S_IDLE : S_XFER;
      end
      S_XFER: begin
        if (xfer_done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Byte capture into the block store
  always_ff @(posedge clk) begin
    if (byte_take) begin
      cb[(state == S_IDLE) ? 4'h0 : idx] <= cmd_byte;
    end
  end

  // Byte index and block size
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx <= 4'h0;
      ten <= 1'b0;
    end else if (byte_take & (state == S_IDLE)) begin
      idx <= CB_NEXT_IDX;
      ten <= in_group == GRP_LONG;
    end else if (byte_take) begin
      idx <= idx + 4'h1;
    end
  end

  // Outcome pulses of the first byte, of the check and of the phase end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_valid  <= 1'b0;
      cmd_reject <= 1'b0;
      vendor_cmd <= 1'b0;
      cmd_done   <= 1'b0;
    end else begin
      cmd_valid  <= xfer_start;
      // Unimplemented and reserved groups, or bad fields
      cmd_reject <= (byte_take & (state == S_IDLE) & ~in_known
                     & ~in_vendor)
                  | ((state == S_CHECK) & param_bad);
      vendor_cmd <= byte_take & (state == S_IDLE) & in_vendor;
      cmd_done   <= (state == S_XFER) & xfer_done;
    end
  end

  // Decoded command and phase setup, loaded once the block passes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_info       <= '0;
      cmd_count      <= 17'h00000;
      xfer_bytes     <= 17'h00000;
      over_recommend <= 1'b0;
      xfer_dir_in    <= 1'b0;
      cur_kind       <= LEN_NONE;
    end else if (xfer_start) begin
      cmd_info.group       <= cb[BYTE_OPC][OPC_GRP_MSB:OPC_GRP_LSB];
      cmd_info.command     <= cb[BYTE_OPC][OPC_CMD_MSB:0];
      cmd_info.unit_number <= f_unit;
      cmd_info.lba         <= f_lba;
      cmd_info.length      <= f_len;
      cmd_info.control     <= f_ctl;
      cmd_info.ten_byte    <= ten;
      cmd_count            <= f_count;
      xfer_bytes           <= phase_limit;
      over_recommend <= {16'h0000, phase_limit} > RECOMMEND_BYTES;
      xfer_dir_in          <= dir_in;
      cur_kind             <= len_kind;
    end
  end

  // ------------------------------------------------------------------
  // Data phase counter
  // ------------------------------------------------------------------
  cbd_xfer u_xfer (
    .clk       (clk),
    .reset     (reset),
    .start     (xfer_start),
    .limit     (phase_limit),
    .beat      (data_beat),
    .active    (xfer_active),
    .remaining (xfer_remaining),
    .done      (xfer_done)
  );

  // Medium is written only by a passed block-write phase
  assign medium_write_en = xfer_active & ~xfer_dir_in
                         & (cur_kind == LEN_BLOCKS);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb_clk @(posedge clk); endclocking
  default disable iff (reset);

  property p_group_refuse;
    byte_take && state == S_IDLE && !in_known && !in_vendor
      |=> cmd_reject && state == S_IDLE;
  endproperty
  a_group_refuse: assert property (p_group_refuse)
    else $error("reserved group not refused");

  property p_block_len;
    byte_take && state == S_IDLE && in_group == GRP_SHORT
      ##1 (cmd_byte_valid [*5]) |=> state == S_CHECK;
  endproperty
  a_block_len: assert property (p_block_len)
    else $error("short block not six bytes");

  property p_short_zero;
    cmd_valid && !cmd_info.ten_byte && cmd_info.length == 16'h0000
      |-> cmd_count == SHORT_ZERO_COUNT;
  endproperty
  a_short_zero: assert property (p_short_zero)
    else $error("short zero length not 256");

  property p_long_zero;
    cmd_valid && cmd_info.ten_byte && cmd_info.length == 16'h0000
      |-> cmd_count == 17'h00000;
  endproperty
  a_long_zero: assert property (p_long_zero)
    else $error("long zero length moved data");

  property p_no_write;
    cmd_reject |-> !medium_write_en [*3];
  endproperty
  a_no_write: assert property (p_no_write)
    else $error("medium written after refusal");

  property p_cap;
    xfer_active |-> {16'h0000, xfer_remaining} <= MAX_XFER_BYTES;
  endproperty
  a_cap: assert property (p_cap)
    else $error("phase above 64 kilobytes");

  property p_alloc_min;
    xfer_start && len_kind == LEN_ALLOC |=> xfer_bytes <= $past(data_avail)
      && xfer_bytes <= $past(f_count);
  endproperty
  a_alloc_min: assert property (p_alloc_min)
    else $error("allocation limit exceeded");

  property p_alloc_zero;
    xfer_start && len_kind == LEN_ALLOC && f_count == 17'h00000
      |=> cmd_valid && xfer_done ##1 cmd_done;
  endproperty
  a_alloc_zero: assert property (p_alloc_zero)
    else $error("zero allocation not ended cleanly");

  property p_unit_pick;
    xfer_start && !identify_valid
      |=> cmd_info.unit_number == $past(cb[BYTE_UNIT][UNIT_MSB:UNIT_LSB]);
  endproperty
  a_unit_pick: assert property (p_unit_pick)
    else $error("unit not taken from byte one");

  c_long_cmd: cover property (cmd_valid && cmd_info.ten_byte);
  c_reject: cover property (state == S_CHECK && param_bad);
  c_vendor: cover property (vendor_cmd);
  c_write_done: cover property (medium_write_en ##1 cmd_done);

endmodule

// [sim/cbd_initiator.sv]
// Behavioural initiator that hands a command block to the decoder.
// Assumes the caller composes the block; bytes leave in order on clk.
`timescale 1ns/1ps
module cbd_initiator (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic [79:0] blk,
  input  wire logic [3:0]  nbytes,
  input  wire logic        cmd_byte_ready,
  output logic             cmd_byte_valid,
  output logic [7:0]       cmd_byte
);
  // ------------------------------------------------------------------
  // Byte sender
  // ------------------------------------------------------------------
  logic [3:0]  idx;
  logic [79:0] shifted;

  // Block shifted so the next byte sits on top
  assign shifted = blk << {idx, 3'h0};

  // Byte 0 first, control byte last, held until taken
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_byte_valid <= 1'b0;
      cmd_byte       <= 8'h5a;
      idx            <= 4'h0;
    end else if (!cmd_byte_valid && start) begin
      cmd_byte_valid <= 1'b1;
      cmd_byte       <= blk[79:72];
      idx            <= 4'h1;
    end else if (cmd_byte_valid && cmd_byte_ready) begin
      if (idx == nbytes) begin
        cmd_byte_valid <= 1'b0;
        cmd_byte       <= ~cmd_byte; // Released bus shows no stale byte
      end else begin
        cmd_byte <= shifted[79:72];
        idx      <= idx + 4'h1;
      end
    end
  end
endmodule

// [sim/tb.sv]
// Self-checking bench for the command block decoder.
// Assumes cbd_pkg and the decoder are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
module tb;
  import cbd_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic              clk, reset, start, identify_valid, dir_in, data_beat;
  logic              cmd_byte_valid, cmd_byte_ready, cmd_valid, cmd_reject;
  logic              vendor_cmd, over_recommend, xfer_active, xfer_dir_in;
  logic              xfer_done, medium_write_en, cmd_done;
  logic [7:0]        cmd_byte;
  logic [2:0]        identify_unit;
  cbd_len_kind_type  len_kind;
  logic [16:0]       data_avail, cmd_count, xfer_bytes, xfer_remaining;
  logic [31:0]       unit_blocks;
  logic [3:0]        blk_log2, nbytes;
  logic [79:0]       blk;
  cbd_cmd_type       cmd_info;
  int                mismatches, samples_checked;

  cbd_initiator cbd_initiator_inst (.clk(clk), .reset(reset), .start(start),
    .blk(blk), .nbytes(nbytes), .cmd_byte_ready(cmd_byte_ready),
    .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte));

  cbd_decoder cbd_decoder_inst (.clk(clk), .reset(reset),
    .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte),
    .cmd_byte_ready(cmd_byte_ready), .identify_valid(identify_valid),
    .identify_unit(identify_unit), .len_kind(len_kind), .dir_in(dir_in),
    .data_avail(data_avail), .unit_blocks(unit_blocks),
    .blk_log2(blk_log2), .data_beat(data_beat), .cmd_info(cmd_info),
    .cmd_count(cmd_count), .xfer_bytes(xfer_bytes), .cmd_valid(cmd_valid),
    .cmd_reject(cmd_reject), .vendor_cmd(vendor_cmd),
    .over_recommend(over_recommend), .xfer_active(xfer_active),
    .xfer_dir_in(xfer_dir_in), .xfer_remaining(xfer_remaining),
    .xfer_done(xfer_done), .medium_write_en(medium_write_en),
    .cmd_done(cmd_done));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Short block, unit and control byte set zero here
  function automatic logic [79:0] sht(input logic [7:0] op,
    input logic [20:0] lba, input logic [7:0] len);
    return {op, 3'h0, lba, len, 8'h00, 32'h0};
  endfunction

  // Long block, reserved bits of byte one and byte six zero
  function automatic logic [79:0] lng(input logic [7:0] op,
    input logic [2:0] un, input logic [31:0] lba, input logic [15:0] len,
    input logic [7:0] ctl);
    return {op, un, 5'h00, lba, 8'h00, len, ctl};
  endfunction

  task automatic ck(input string nm, input logic [31:0] e,
                    input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cfg(input cbd_len_kind_type k, input logic d,
    input logic [16:0] av, input logic [31:0] ub, input logic [3:0] lg,
    input logic iv, input logic [2:0] iu);
    @(posedge clk);
    len_kind       <= k;
    dir_in         <= d;
    data_avail     <= av;
    unit_blocks    <= ub;
    blk_log2       <= lg;
    identify_valid <= iv;
    identify_unit  <= iu;
  endtask

  task automatic send(input logic [79:0] b, input logic [3:0] n);
    @(posedge clk);
    blk    <= b;
    nbytes <= n;
    start  <= 1'b1;
    @(posedge clk);
    start  <= 1'b0;
  endtask

  // Wait for the decoder's verdict, then judge it
  task automatic ans(input logic v, input logic r, input logic vd);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if ((cmd_valid | cmd_reject | vendor_cmd) === 1'b1) break;
    end
    ck("cmd_valid", v, cmd_valid);
    ck("cmd_reject", r, cmd_reject);
    ck("vendor_cmd", vd, vendor_cmd);
  endtask

  // Data phase of n bytes, one beat per cycle
  task automatic run(input logic [16:0] n, input logic m);
    int i;
    ck("medium_write_en", m, medium_write_en);
    ck("cmd_byte_ready", 0, cmd_byte_ready);
    if (n == 17'h0) begin
      ck("xfer_done", 1, xfer_done);
    end else begin
      ck("xfer_remaining", n, xfer_remaining);
      ck("xfer_active", 1, xfer_active);
      for (i = 0; i < n; i++) @(posedge clk) data_beat <= 1'b1;
      @(posedge clk) data_beat <= 1'b0;
      @(negedge clk);
      ck("xfer_done", 1, xfer_done);
      ck("xfer_active", 0, xfer_active);
    end
    @(negedge clk);
    ck("cmd_done", 1, cmd_done);
    ck("cmd_byte_ready", 1, cmd_byte_ready);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_short;
    cfg(LEN_ALLOC, 1'b1, 17'h00040, 32'h0, 4'h0, 1'b0, 3'h0);
    send(sht(8'h03, 21'h012345, 8'h00), 4'h6);
    ans(1'b1, 1'b0, 1'b0);
    ck("command", 32'h3, cmd_info.command);
    ck("lba", 32'h12345, cmd_info.lba);
    ck("ten_byte", 0, cmd_info.ten_byte);
    // Short zero allocation reads as 256, so the data cap wins
    ck("cmd_count", 32'h100, cmd_count);
    ck("xfer_bytes", 32'h40, xfer_bytes);
    ck("control", 32'h0, cmd_info.control);
    run(17'h00040, 1'b0);
    cfg(LEN_BLOCKS, 1'b0, 17'h0, 32'h00001000, 4'h0, 1'b0, 3'h0);
    send(sht(8'h0a, 21'h000010, 8'h00), 4'h6);
    ans(1'b1, 1'b0, 1'b0);
    ck("cmd_count", 32'h100, cmd_count);
    run(17'h00100, 1'b1);
  endtask

  task automatic t_long;
    cfg(LEN_PARAM, 1'b0, 17'h0, 32'h0, 4'h0, 1'b0, 3'h0);
    send(lng(8'h3b, 3'h0, 32'h89abcdef, 16'h0003, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    ck("group", 32'h1, cmd_info.group);
    ck("command", 32'h1b, cmd_info.command);
    ck("lba", 32'h89abcdef, cmd_info.lba);
    ck("length", 32'h3, cmd_info.length);
    run(17'h00003, 1'b0);
    cfg(LEN_ALLOC, 1'b1, 17'h00020, 32'h0, 4'h0, 1'b0, 3'h0);
    send(lng(8'h25, 3'h0, 32'h0, 16'h0100, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    ck("xfer_dir_in", 1, xfer_dir_in);
    ck("xfer_bytes", 32'h20, xfer_bytes);
    ck("over_recommend", 0, over_recommend);
    run(17'h00020, 1'b0);
    cfg(LEN_BLOCKS, 1'b0, 17'h0, 32'h00000001, 4'h0, 1'b0, 3'h0);
    send(lng(8'h28, 3'h0, 32'h0, 16'h0000, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    run(17'h0, 1'b0);
  endtask

  task automatic t_groups;
    int g;
    for (g = 2; g < 8; g++) begin
      send({g[2:0], 5'h01, 72'h0}, 4'h1);
      ans(1'b0, g < 6, g > 5);
    end
  endtask

  task automatic t_bad;
    cfg(LEN_BLOCKS, 1'b0, 17'h0, 32'h00000100, 4'h0, 1'b0, 3'h0);
    send(lng(8'h2a, 3'h0, 32'hff, 16'h0002, 8'h00), 4'ha);
    ans(1'b0, 1'b1, 1'b0);
    ck("medium_write_en", 0, medium_write_en);
    send(lng(8'h2a, 3'h0, 32'hff, 16'h0001, 8'h01), 4'ha);
    ans(1'b0, 1'b1, 1'b0);
    send(lng(8'h2a, 3'h0, 32'hff, 16'h0001, 8'h00) | (80'h1 << 24), 4'ha);
    ans(1'b0, 1'b1, 1'b0);
    send(lng(8'h2a, 3'h0, 32'hff, 16'h0001, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    run(17'h00001, 1'b1);
    cfg(LEN_ALLOC, 1'b1, 17'h0, 32'h0, 4'h0, 1'b1, 3'h2);
    send(lng(8'h25, 3'h5, 32'h0, 16'h0000, 8'h00), 4'ha);
    ans(1'b0, 1'b1, 1'b0);
    cfg(LEN_ALLOC, 1'b1, 17'h0, 32'h0, 4'h0, 1'b0, 3'h0);
    send(lng(8'h25, 3'h5, 32'h0, 16'h0000, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    ck("unit_number", 32'h5, cmd_info.unit_number);
    run(17'h0, 1'b0);
  endtask

  task automatic t_limit;
    cfg(LEN_BLOCKS, 1'b0, 17'h0, 32'hffffffff, 4'h9, 1'b0, 3'h0);
    send(lng(8'h2a, 3'h0, 32'h0, 16'h0081, 8'h00), 4'ha);
    ans(1'b0, 1'b1, 1'b0);
    cfg(LEN_ALLOC, 1'b1, 17'h1ffff, 32'h0, 4'h0, 1'b0, 3'h0);
    send(lng(8'h25, 3'h0, 32'h0, 16'h4001, 8'h00), 4'ha);
    ans(1'b1, 1'b0, 1'b0);
    ck("over_recommend", 1, over_recommend);
    run(17'h04001, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Free-running 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, about twice the expected run
  initial begin
    #(40000 * 50);
    mismatches++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    start = 1'b0;
    blk = 80'h0;
    nbytes = 4'h0;
    data_beat = 1'b0;
    identify_valid = 1'b0;
    identify_unit = 3'h0;
    len_kind = LEN_NONE;
    dir_in = 1'b0;
    data_avail = 17'h0;
    unit_blocks = 32'h0;
    blk_log2 = 4'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_short();
    t_long();
    t_groups();
    t_bad();
    t_limit();
    tally_and_finish();
  end
endmodule
